// ---- design/ipt_ctrl.v ----
// Power control unit of the inductive power transmitter with APB registers
`timescale 1ns/1ps
`include "ipt_map.vh"
module ipt_ctrl #(
    parameter [15:0] ITER_CYC = `IPT_ITER_CYC // Cycles between PID iterations
) (
    input wire clock, // 10 MHz system clock
    input wire rst_n, // Synchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error on unmapped address
    input wire [11:0] coil_current, // Coil current amplitude, 1 mA per LSB
    input wire period_end, // Inverter end-of-period pulse
    output reg power_on, // Inverter running
    output reg half_bridge, // Half-bridge drive when set
    output reg [18:0] inverter_operating_frequency, // In 0.5 Hz units
    output reg [14:0] phase_diff, // In 0.009 degree units
    output reg [12:0] duty, // In 0.01 percent units
    output reg [13:0] rail_mv, // Inverter input voltage setpoint
    output wire cap_not_res_sens // Capability flag reported to the receiver
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_WAIT = 2'd1;
    localparam [1:0] S_STEP = 2'd2;

    reg [11:0] cur_s1_r;
    reg [11:0] cur_s2_r;
    reg pe_s1_r;
    reg pe_s2_r;
    reg pe_s3_r;
    reg pwr_en_r;
    reg signed [15:0] target_r;
    reg [18:0] freq_r;
    reg [14:0] phase_r;
    reg [12:0] duty_r;
    reg hb_r;
    reg [1:0] cv_r;
    reg [1:0] st_r;
    reg [15:0] tick_r;
    reg [3:0] iter_r;
    reg abort_r;
    reg signed [31:0] freq_nxt;
    reg signed [31:0] phase_nxt;
    reg signed [31:0] duty_nxt;
    reg hb_nxt;
    reg [1:0] cv_nxt;
    reg trans_hit;
    reg signed [31:0] sv;
    reg signed [31:0] dv;
    reg signed [31:0] tgt;
    reg [3:0] kp;
    reg [31:0] rd_val;
    reg rd_hit;

    wire acc = psel && penable;
    wire wr_ctrl = acc && pwrite && (paddr == `IPT_OFF_CTRL);
    wire wr_cep = acc && pwrite && (paddr == `IPT_OFF_CEP);
    wire wr_stat = acc && pwrite && (paddr == `IPT_OFF_STATUS);
    wire ping = wr_ctrl && pwdata[`IPT_CTRL_PING_BIT];
    wire pe_evt = pe_s2_r && !pe_s3_r;
    wire step = (st_r == S_WAIT) && (tick_r == ITER_CYC - 16'd1);
    wire loop_start = wr_cep && pwr_en_r && !ping;
    wire signed [15:0] meas = $signed({4'h0, cur_s2_r});
    wire signed [15:0] err = target_r - meas;
    wire signed [23:0] u;

    assign pready = 1'b1;
    assign pslverr = acc && !rd_hit;
    assign cap_not_res_sens = 1'b0;

    // Pins pass two flops before use
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            cur_s1_r <= 12'h000;
            cur_s2_r <= 12'h000;
            pe_s1_r <= 1'b0;
            pe_s2_r <= 1'b0;
            pe_s3_r <= 1'b0;
        end
        else
        begin
            cur_s1_r <= coil_current;
            cur_s2_r <= cur_s1_r;
            pe_s1_r <= period_end;
            pe_s2_r <= pe_s1_r;
            pe_s3_r <= pe_s2_r;
        end
    end

    // Gains follow the variable under control
    always @*
    begin
        case (cv_r)
            `IPT_CV_FREQ_HB: kp = `IPT_KP_FREQ_HB;
            `IPT_CV_FREQ_FB: kp = `IPT_KP_FREQ_FB;
            `IPT_CV_PHASE: kp = `IPT_KP_PHASE;
            `IPT_CV_DUTY: kp = `IPT_KP_DUTY;
            default: kp = `IPT_KP_PHASE;
        endcase
    end

    ipt_pid u_pid (
        .clock(clock),
        .rst_n(rst_n),
        .clear(loop_start),
        .step(step),
        .err(err),
        .kp(kp),
        .kd_en(cv_r == `IPT_CV_FREQ_HB || cv_r == `IPT_CV_FREQ_FB),
        .u_r(u)
    );

    // Scaling band read from the present frequency at every iteration
    always @*
    begin
        case (cv_r)
            `IPT_CV_PHASE: sv = `IPT_SV_PHASE;
            `IPT_CV_DUTY: sv = `IPT_SV_DUTY;
            default:
            begin
                if (freq_r < `IPT_FREQ_BAND1)
                    sv = `IPT_SV_BAND0;
                else if (freq_r < `IPT_FREQ_BAND2)
                    sv = `IPT_SV_BAND1;
                else if (freq_r < `IPT_FREQ_BAND3)
                    sv = `IPT_SV_BAND2;
                else
                    sv = `IPT_SV_BAND3;
            end
        endcase
        dv = sv * u;
    end

    // New setpoint: v minus scaled output, so positive output raises power
    always @*
    begin
        freq_nxt = $signed({13'h0000, freq_r});
        phase_nxt = $signed({17'h00000, phase_r});
        duty_nxt = $signed({19'h00000, duty_r});
        hb_nxt = hb_r;
        cv_nxt = cv_r;
        trans_hit = 1'b0;
        case (cv_r)
            `IPT_CV_FREQ_HB:
            begin
                freq_nxt = freq_nxt - dv;
                if (freq_nxt <= `IPT_FREQ_TRANS)
                begin
                    freq_nxt = `IPT_FREQ_TRANS;
                    phase_nxt = `IPT_PHASE_MAX;
                    hb_nxt = 1'b0;
                    cv_nxt = `IPT_CV_PHASE;
                    trans_hit = 1'b1;
                end
                else if (freq_nxt >= `IPT_FREQ_MAX)
                begin
                    freq_nxt = `IPT_FREQ_MAX;
                    cv_nxt = `IPT_CV_DUTY;
                end
            end
            `IPT_CV_DUTY:
            begin
                duty_nxt = duty_nxt - dv;
                if (duty_nxt >= `IPT_DUTY_MAX)
                begin
                    duty_nxt = `IPT_DUTY_MAX;
                    cv_nxt = `IPT_CV_FREQ_HB;
                end
                else if (duty_nxt < `IPT_DUTY_MIN)
                    duty_nxt = `IPT_DUTY_MIN;
            end
            `IPT_CV_PHASE:
            begin
                phase_nxt = phase_nxt - dv;
                if (phase_nxt > `IPT_PHASE_MAX)
                begin
                    phase_nxt = 0;
                    duty_nxt = `IPT_DUTY_MAX;
                    hb_nxt = 1'b1;
                    cv_nxt = `IPT_CV_FREQ_HB;
                    trans_hit = 1'b1;
                end
                else if (phase_nxt <= 0)
                begin
                    phase_nxt = 0;
                    cv_nxt = `IPT_CV_FREQ_FB;
                end
            end
            default:
            begin
                freq_nxt = freq_nxt - dv;
                if (freq_nxt >= `IPT_FREQ_TRANS)
                begin
                    freq_nxt = `IPT_FREQ_TRANS;
                    cv_nxt = `IPT_CV_PHASE;
                end
                else if (freq_nxt < `IPT_FREQ_MIN)
                    freq_nxt = `IPT_FREQ_MIN;
            end
        endcase
    end

    // Target current from the signed control error in 1/128 steps
    always @*
    begin
        tgt = meas;
        tgt = tgt + ((tgt * $signed(pwdata[7:0])) >>> 7);
    end

    // Loop sequencer and working setpoints
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            pwr_en_r <= 1'b0;
            target_r <= 16'h0000;
            freq_r <= `IPT_FREQ_PING;
            phase_r <= 15'h0000;
            duty_r <= `IPT_DUTY_RST;
            hb_r <= 1'b1;
            cv_r <= `IPT_CV_FREQ_HB;
            st_r <= S_IDLE;
            tick_r <= 16'h0000;
            iter_r <= 4'h0;
            abort_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                pwr_en_r <= pwdata[`IPT_CTRL_PWR_BIT] || ping;
            if (wr_stat && pwdata[`IPT_ST_ABORT_BIT])
                abort_r <= 1'b0;
            if (ping || (wr_ctrl && !pwdata[`IPT_CTRL_PWR_BIT]))
            begin
                freq_r <= `IPT_FREQ_PING;
                duty_r <= `IPT_DUTY_RST;
                phase_r <= 15'h0000;
                hb_r <= 1'b1;
                cv_r <= `IPT_CV_FREQ_HB;
                st_r <= S_IDLE;
            end
            else if (loop_start)
            begin
                target_r <= tgt[15:0];
                iter_r <= `IPT_PID_ITERS;
                tick_r <= 16'h0000;
                st_r <= S_WAIT;
            end
            else
            begin
                case (st_r)
                    S_WAIT:
                    begin
                        tick_r <= tick_r + 16'd1;
                        if (step)
                        begin
                            tick_r <= 16'h0000;
                            st_r <= S_STEP;
                        end
                    end
                    S_STEP:
                    begin
                        freq_r <= freq_nxt[18:0];
                        phase_r <= phase_nxt[14:0];
                        duty_r <= duty_nxt[12:0];
                        hb_r <= hb_nxt;
                        cv_r <= cv_nxt;
                        iter_r <= iter_r - 4'd1;
                        // Stop here and wait for a fresh error packet
                        if (trans_hit || iter_r == 4'd1)
                            st_r <= S_IDLE;
                        else
                            st_r <= S_WAIT;
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
            // Set beats a same-cycle clear
            if (st_r == S_STEP && trans_hit && !ping)
                abort_r <= 1'b1;
        end
    end

    // Drive outputs move only at a period boundary while running and follow every cycle while off, so no pulse is cut or overlapped
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            power_on <= 1'b0;
            half_bridge <= 1'b1;
            inverter_operating_frequency <= `IPT_FREQ_PING;
            phase_diff <= 15'h0000;
            duty <= `IPT_DUTY_RST;
            rail_mv <= 14'h0000;
        end
        else if (pe_evt || !power_on)
        begin
            power_on <= pwr_en_r;
            half_bridge <= hb_r;
            inverter_operating_frequency <= freq_r;
            phase_diff <= phase_r;
            duty <= duty_r;
            rail_mv <= pwr_en_r ? `IPT_RAIL_MV : 14'h0000;
        end
    end

    // Register read decode
    always @*
    begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        case (paddr)
            `IPT_OFF_CTRL: rd_val = {31'h00000000, pwr_en_r};
            `IPT_OFF_CEP: rd_val = {16'h0000, target_r};
            `IPT_OFF_STATUS: rd_val = {26'h0000000, cap_not_res_sens, abort_r,
                                       st_r != S_IDLE, half_bridge, cv_r};
            `IPT_OFF_FREQ: rd_val = {13'h0000, inverter_operating_frequency};
            `IPT_OFF_PHASE: rd_val = {17'h00000, phase_diff};
            `IPT_OFF_DUTY: rd_val = {19'h00000, duty};
            `IPT_OFF_CURRENT: rd_val = {20'h00000, cur_s2_r};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read data latched in the setup cycle, valid through the access cycle
    always @(posedge clock)
    begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= (!pwrite && rd_hit) ? rd_val : 32'h00000000;
    end
endmodule // ipt_ctrl

// ---- design/ipt_map.vh ----
// Register map, limits and PID constants of the inductive power transmitter controller
// Contract
// - Frequency 110-205 kHz, phase 0-133 degrees, duty 10-50 percent.
// - Higher frequency, higher phase or lower duty means less power.
// - Frequency step finer than 0.01f-0.7 kHz or 0.015f-1.58 kHz by range.
// - Phase difference adjusts in steps of 0.18 degrees or finer.
// - Duty cycle adjusts in steps of 0.1 percent or finer.
// - Ping starts half-bridge at 175 kHz, 50 percent duty, 12 V rail.
// - PID loop drives frequency, duty or phase as the power demand needs.
// - Coil current amplitude measured with 7 mA resolution or finer.
// - At 205 kHz run half-bridge with duty control between 10 and 50 percent.
// - Between 172 and 205 kHz run half-bridge at 50 percent, frequency control.
// - At 172 kHz run full-bridge with phase control from 0 to 133 degrees.
// - Below 172 kHz run full-bridge, zero phase, frequency control.
// - Falling to 172 kHz switches to full-bridge at 133 degrees.
// - Rising past 133 degrees at 172 kHz switches to half-bridge.
// - Hitting the transition mid-loop abandons the loop until the next error packet.
// - Half-bridge frequency PID gains 10, 1, 1; limits 3000 and 20000.
// - Full-bridge frequency PID gains 5, 1, 1; limits 3000 and 20000.
// - Frequency scaling 1.5, 2, 3, 5 Hz by frequency band.
// - Phase PID gains 1, 1, 0; limits 3000, 20000; scaling 0.009 degrees.
// - Duty PID gains 10, 1, 0; limits 3000, 20000; scaling -0.01 percent.
// - Resonance-sensing-absent capability flag is always zero.
`ifndef IPT_MAP_VH
`define IPT_MAP_VH
`define IPT_OFF_CTRL 8'h00
`define IPT_OFF_CEP 8'h04
`define IPT_OFF_STATUS 8'h08
`define IPT_OFF_FREQ 8'h0c
`define IPT_OFF_PHASE 8'h10
`define IPT_OFF_DUTY 8'h14
`define IPT_OFF_CURRENT 8'h18
`define IPT_CTRL_PWR_BIT 0
`define IPT_CTRL_PING_BIT 1
`define IPT_ST_ABORT_BIT 4
// Frequency in 0.5 Hz units, phase in 0.009 degree units, duty in 0.01 percent units
`define IPT_FREQ_MIN 220000
`define IPT_FREQ_MAX 410000
`define IPT_FREQ_TRANS 344000
`define IPT_FREQ_PING 19'd350000
`define IPT_FREQ_BAND1 280000
`define IPT_FREQ_BAND2 320000
`define IPT_FREQ_BAND3 360000
`define IPT_SV_BAND0 3
`define IPT_SV_BAND1 4
`define IPT_SV_BAND2 6
`define IPT_SV_BAND3 10
`define IPT_SV_PHASE 1
`define IPT_SV_DUTY (-1)
`define IPT_PHASE_MAX 14777
`define IPT_DUTY_MIN 1000
`define IPT_DUTY_MAX 5000
`define IPT_DUTY_RST 13'd5000
`define IPT_RAIL_MV 14'd12000
`define IPT_KP_FREQ_HB 4'd10
`define IPT_KP_FREQ_FB 4'd5
`define IPT_KP_PHASE 4'd1
`define IPT_KP_DUTY 4'd10
`define IPT_I_LIM 3000
`define IPT_PID_LIM 20000
`define IPT_CV_FREQ_HB 2'd0
`define IPT_CV_DUTY 2'd1
`define IPT_CV_PHASE 2'd2
`define IPT_CV_FREQ_FB 2'd3
`define IPT_PID_ITERS 4'd8
`define IPT_CLK_MHZ 10
`define IPT_ITER_US 1000
`define IPT_ITER_CYC (`IPT_ITER_US * `IPT_CLK_MHZ)
`endif

// ---- design/ipt_pid.v ----
// One PID iteration with clamped integral and clamped output
`timescale 1ns/1ps
`include "ipt_map.vh"
module ipt_pid (
    input wire clock, // System clock
    input wire rst_n, // Synchronous reset, active low
    input wire clear, // Restart integral and derivative history
    input wire step, // Run one iteration
    input wire signed [15:0] err, // Current error in mA
    input wire [3:0] kp, // Proportional gain
    input wire kd_en, // Derivative gain one when set
    output reg signed [23:0] u_r // PID output, valid the cycle after step
);
    reg signed [15:0] integ_r;
    reg signed [15:0] eprev_r;
    reg signed [31:0] isum;
    reg signed [31:0] tot;

    // Ki is one per mA per iteration, so the integral simply accumulates the error
    always @*
    begin
        isum = integ_r + err;
        if (isum > `IPT_I_LIM)
            isum = `IPT_I_LIM;
        else if (isum < -`IPT_I_LIM)
            isum = -`IPT_I_LIM;
        tot = $signed({1'b0, kp}) * err + isum;
        if (kd_en)
            tot = tot + err - eprev_r;
        if (tot > `IPT_PID_LIM)
            tot = `IPT_PID_LIM;
        else if (tot < -`IPT_PID_LIM)
            tot = -`IPT_PID_LIM;
    end

    always @(posedge clock)
    begin
        if (!rst_n || clear)
        begin
            integ_r <= 16'h0000;
            eprev_r <= 16'h0000;
            u_r <= 24'h000000;
        end
        else if (step)
        begin
            integ_r <= isum[15:0];
            eprev_r <= err;
            u_r <= tot[23:0];
        end
    end
endmodule // ipt_pid

// ---- testbench/ipt_ctrl_assertions.sv ----
// Assertions on the drive outputs of the power control unit
`timescale 1ns/1ps
`include "ipt_map.vh"
module ipt_ctrl_checker #(
    parameter [15:0] ITER_CYC = 16'h000c // Cycles per iteration
) (
    input wire clock, // Clock
    input wire rst_n, // Reset
    input wire power_on, // Running
    input wire half_bridge, // Bridge mode
    input wire [18:0] inverter_operating_frequency, // Frequency
    input wire [14:0] phase_diff, // Phase
    input wire [12:0] duty, // Duty
    input wire [13:0] rail_mv, // Rail
    input wire cap_not_res_sens // Flag
);
    wire [31:0] f = {13'h0000, inverter_operating_frequency};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    freq_range_a: assert property (f >= `IPT_FREQ_MIN && f <= `IPT_FREQ_MAX)
        else $error("freq range");
    phase_range_a: assert property (phase_diff <= `IPT_PHASE_MAX)
        else $error("phase range");
    duty_range_a: assert property (duty >= `IPT_DUTY_MIN && duty <= `IPT_DUTY_MAX)
        else $error("duty range");
    hb_duty_a: assert property (half_bridge && f != `IPT_FREQ_MAX |-> duty == `IPT_DUTY_MAX)
        else $error("half-bridge duty");
    hb_band_a: assert property (half_bridge |-> f >= `IPT_FREQ_TRANS && phase_diff == 15'h0000)
        else $error("half-bridge band");
    fb_band_a: assert property (!half_bridge |-> f <= `IPT_FREQ_TRANS)
        else $error("full-bridge band");
    fb_phase_a: assert property (!half_bridge && f < `IPT_FREQ_TRANS |-> phase_diff == 15'h0000)
        else $error("full-bridge phase");
    down_switch_a: assert property ($fell(half_bridge) |-> f == `IPT_FREQ_TRANS && phase_diff == `IPT_PHASE_MAX)
        else $error("down switch");
    up_switch_a: assert property ($rose(half_bridge) && f != `IPT_FREQ_PING |-> f == `IPT_FREQ_TRANS)
        else $error("up switch");
    rail_level_a: assert property (rail_mv == (power_on ? `IPT_RAIL_MV : 14'h0000))
        else $error("rail level");
    cap_flag_a: assert property (cap_not_res_sens == 1'b0)
        else $error("cap flag");
    cover property ($fell(half_bridge));
    cover property ($rose(half_bridge) && f == `IPT_FREQ_TRANS);
    cover property (half_bridge && duty == `IPT_DUTY_MIN);
    cover property (!half_bridge && f < `IPT_FREQ_TRANS);
endmodule // ipt_ctrl_checker
bind ipt_ctrl ipt_ctrl_checker #(.ITER_CYC(ITER_CYC)) i_chk (.clock(clock), .rst_n(rst_n), .power_on(power_on),
    .half_bridge(half_bridge), .inverter_operating_frequency(inverter_operating_frequency),
    .phase_diff(phase_diff), .duty(duty), .rail_mv(rail_mv), .cap_not_res_sens(cap_not_res_sens));

// ---- testbench/ipt_inv_model.sv ----
// Inverter and coil current sense model
`timescale 1ns/1ps
module ipt_inv_model (
    input wire clock, // Clock
    input wire power_on, // Bridge running
    input wire [7:0] period_cyc, // Period in clocks minus one, at least 3
    input wire [11:0] level_ma, // Coil current when running
    output wire [11:0] coil_current, // Current amplitude
    output wire period_end // Two clocks wide
);
    reg [11:0] cur_r = 12'h000;
    reg [7:0] cnt_r = 8'h00;
    reg end_r = 1'b0;
    assign coil_current = cur_r;
    assign period_end = end_r;
    always @(posedge clock)
    begin
        // Idle bridge: no current, no period marks
        cur_r <= power_on ? level_ma : 12'h000;
        cnt_r <= (!power_on || cnt_r >= period_cyc) ? 8'h00 : cnt_r + 8'h01;
        end_r <= power_on && cnt_r < 8'h02;
    end
endmodule // ipt_inv_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the power control unit
`timescale 1ns/1ps
`include "ipt_map.vh"
module testbench;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    reg [7:0] paddr = 8'h00, per = 8'h10;
    reg [31:0] pwdata = 32'h0, seed = 32'hfd76d50e, rd, pv;
    reg [31:0] sv [0:3];
    reg [11:0] lvl = 12'h000;
    reg [1:0] pcv;
    integer num_errors = 0;
    integer check_count = 0;
    integer i, k;
    wire [31:0] prdata;
    wire pready, pslverr, power_on, half_bridge, pend, cap;
    wire [18:0] freq;
    wire [14:0] phase;
    wire [12:0] duty;
    wire [13:0] rail;
    wire [11:0] cur;
    ipt_ctrl #(.ITER_CYC(16'h000c)) i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .coil_current(cur), .period_end(pend), .power_on(power_on), .half_bridge(half_bridge),
        .inverter_operating_frequency(freq), .phase_diff(phase), .duty(duty), .rail_mv(rail),
        .cap_not_res_sens(cap));
    ipt_inv_model i_inv (.clock(clock), .power_on(power_on), .period_cyc(per), .level_ma(lvl),
        .coil_current(cur), .period_end(pend));
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
    begin
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    end
    endfunction
    function [31:0] tgt(input integer c, input integer e);
        tgt = c + ((c * e) >>> 7);
    endfunction
    function integer vi(input [1:0] c);
        vi = (c == 2'h1) ? 3 : (c == 2'h2) ? 2 : 1;
    endfunction
    // More power: duty up, frequency or phase down
    function dir_ok(input [1:0] c, input signed [7:0] e, input [31:0] b, input [31:0] a);
        dir_ok = (e == 0) ? a == b : ((e > 0) == (c == 2'h1)) ? a >= b : a <= b;
    endfunction
    function cv_ok(input [31:0] s, input [31:0] f, input [31:0] p, input [31:0] d);
        case (s[1:0])
            2'h0: cv_ok = s[2] && f >= `IPT_FREQ_TRANS && d == `IPT_DUTY_MAX;
            2'h1: cv_ok = s[2] && f == `IPT_FREQ_MAX;
            2'h2: cv_ok = !s[2] && f == `IPT_FREQ_TRANS;
            default: cv_ok = !s[2] && f <= `IPT_FREQ_TRANS && p == 32'h0;
        endcase
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        @(posedge clock);
        while (pready !== 1'b1)
        begin
            @(posedge clock);
            n = n + 1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n, 0);
    end
    endtask
    task snap;
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            apb(1'b0, 8'h08 + {k[5:0], 2'b00}, 32'h0);
            sv[k] = rd;
        end
    end
    endtask
    // Outputs move only on a period mark after the loop ends
    task settle;
        integer n;
    begin
        repeat (2) @(posedge clock);
        n = 0;
        rd = 32'h8;
        while (rd[3] && n < 60)
        begin
            apb(1'b0, `IPT_OFF_STATUS, 32'h0);
            n = n + 1;
        end
        chk(32'(rd[3]), 32'h0);
        @(posedge pend);
        repeat (4) @(posedge clock);
        apb(1'b0, `IPT_OFF_STATUS, 32'h0);
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    initial
    begin
        forever #50 clock = ~clock;
    end
    // Far beyond the few thousand cycles the run needs
    initial
    begin
        #3000000;
        num_errors = num_errors + 1;
        report_and_stop;
    end
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        snap;
        chk(sv[0] & 32'h3c, 32'h04);
        chk(sv[1], `IPT_FREQ_PING);
        chk(sv[3], `IPT_DUTY_MAX);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        lvl <= 12'h320;
        apb(1'b1, `IPT_OFF_CTRL, 32'h2);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({16'h0, power_on, half_bridge, rail}, {18'h3, `IPT_RAIL_MV});
        apb(1'b1, `IPT_OFF_CEP, 32'h7f);
        apb(1'b0, `IPT_OFF_CEP, 32'h0);
        chk(rd, tgt(800, 127));
        settle;
        chk(rd & 32'h1f, 32'h12);
        chk(32'(phase), `IPT_PHASE_MAX);
        apb(1'b1, `IPT_OFF_STATUS, 32'h10);
        apb(1'b1, `IPT_OFF_CEP, 32'hc0);
        settle;
        chk(rd & 32'h1f, 32'h14);
        chk(32'(freq), `IPT_FREQ_TRANS);
        repeat (2)
        begin
            apb(1'b1, `IPT_OFF_CEP, 32'h80);
            settle;
        end
        chk(rd & 32'h07, 32'h05);
        chk(32'(duty), `IPT_DUTY_MIN);
        // Climb back through 205 kHz and 172 kHz into full-bridge frequency control
        repeat (2)
        begin
            apb(1'b1, `IPT_OFF_CEP, 32'h7f);
            settle;
        end
        chk(rd & 32'h0f, 32'h03);
        chk(32'(phase), 32'h0);
        for (i = 0; i < 24; i = i + 1)
        begin
            seed = xs(seed);
            lvl <= 12'h12c + {3'h0, seed[8:0]};
            per <= 8'h03 + {3'h0, seed[20:16]};
            apb(1'b1, `IPT_OFF_STATUS, 32'h10);
            snap;
            pcv = sv[0][1:0];
            pv = sv[vi(pcv)];
            apb(1'b1, `IPT_OFF_CEP, {24'h0, seed[31:24]});
            settle;
            snap;
            chk(32'(cv_ok(sv[0], sv[1], sv[2], sv[3])), 32'h1);
            if (sv[0][1:0] == pcv && !sv[0][4])
                chk(32'(dir_ok(pcv, seed[31:24], pv, sv[vi(pcv)])), 32'h1);
        end
        apb(1'b1, `IPT_OFF_CTRL, 32'h0);
        apb(1'b1, `IPT_OFF_CEP, 32'h7f);
        // Drive outputs let go only at the next period mark
        while (power_on)
            @(posedge clock);
        snap;
        @(negedge clock);
        chk(sv[0] & 32'h0c, 32'h04);
        chk(sv[1], `IPT_FREQ_PING);
        chk({16'h0, power_on, half_bridge, rail}, 32'h4000);
        report_and_stop;
    end
endmodule // testbench
